// File: rtl/pdp_port_regs.v
// Ports 1-2 direction and output latch registers and port 3 pull-up register behind an APB slave
//
// Operation
// - Pull-up bit 1 on, 0 off
// - Port 3 pull-up register eight bits, clears
// - Direction bit 0 input, 1 output
// - Mode 1: directions all one, inaccessible
// - Modes 2,3: directions reset zero, write-only
// - Port 1,2 latches read/write, clear at reset
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "pdp_regs.vh"
module pdp_port_regs (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire [1:0]  opMode,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    output wire [7:0]  port1Out,
    output wire [7:0]  port1Oe,
    output wire [7:0]  port2Out,
    output wire [7:0]  port2Oe,
    output wire [7:0]  port3PullEn
);
    reg  [7:0]  p3Pull_r;
    reg  [7:0]  p1Dir_r;
    reg  [7:0]  p2Dir_r;
    reg  [7:0]  p1Latch_r;
    reg  [7:0]  p2Latch_r;
    reg  [31:0] rdata_r;
    reg         mode1_r;
    reg  [31:0] rdata_nxt;
    reg         hit;
    wire        acc;
    wire        wrEn;
    wire [9:0]  idx;
    wire        modeIs1;

    assign acc     = psel & penable;
    assign wrEn    = acc & pwrite;
    assign idx     = paddr[11:2];
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = rdata_r;
    assign modeIs1 = (opMode == `PDP_MODE_1);

    // Decode; unmapped addresses answer with an error and read zero
    always @* begin
        rdata_nxt = 32'h00000000;
        hit = 1'b1;
        case (idx)
            {2'h0, `PDP_IDX_P3PULL}:  rdata_nxt = {24'h000000, p3Pull_r};
            {2'h0, `PDP_IDX_P1LATCH}: rdata_nxt = {24'h000000, p1Latch_r};
            {2'h0, `PDP_IDX_P2LATCH}: rdata_nxt = {24'h000000, p2Latch_r};
            {2'h0, `PDP_IDX_P1DIR}:   rdata_nxt = 32'h00000000;
            {2'h0, `PDP_IDX_P2DIR}:   rdata_nxt = 32'h00000000;
            default:                  hit = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            p3Pull_r  <= `PDP_RST_PULL;
            p1Latch_r <= `PDP_RST_LATCH;
            p2Latch_r <= `PDP_RST_LATCH;
            // Mode 1 resets the directions straight to all-output
            p1Dir_r   <= modeIs1 ? `PDP_RST_DIR_M1 : `PDP_RST_DIR_M23;
            p2Dir_r   <= modeIs1 ? `PDP_RST_DIR_M1 : `PDP_RST_DIR_M23;
            rdata_r   <= 32'h00000000;
            mode1_r   <= modeIs1;
        end else begin
            mode1_r <= modeIs1;
            if (mode1_r) begin
                p1Dir_r <= `PDP_RST_DIR_M1;
                p2Dir_r <= `PDP_RST_DIR_M1;
            end else if (wrEn && idx == {2'h0, `PDP_IDX_P1DIR}) begin
                p1Dir_r <= pwdata[7:0];
            end else if (wrEn && idx == {2'h0, `PDP_IDX_P2DIR}) begin
                p2Dir_r <= pwdata[7:0];
            end
            if (wrEn && idx == {2'h0, `PDP_IDX_P3PULL}) begin
                p3Pull_r <= pwdata[7:0];
            end
            if (wrEn && idx == {2'h0, `PDP_IDX_P1LATCH}) begin
                p1Latch_r <= pwdata[7:0];
            end
            if (wrEn && idx == {2'h0, `PDP_IDX_P2LATCH}) begin
                p2Latch_r <= pwdata[7:0];
            end
            // Capture in the setup cycle so read data stands through the access phase
            if (psel && !penable && !pwrite) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Pull-up is a pure register bit on port 3: no drivers here
    assign port3PullEn = p3Pull_r;

    pdp_pin_drive uPort1 (
        .dirBits   (p1Dir_r),
        .latchBits (p1Latch_r),
        .pullBits  (8'h00),
        .pinOut    (port1Out),
        .pinOe     (port1Oe),
        .pullEn    ()
    );

    pdp_pin_drive uPort2 (
        .dirBits   (p2Dir_r),
        .latchBits (p2Latch_r),
        .pullBits  (8'h00),
        .pinOut    (port2Out),
        .pinOe     (port2Oe),
        .pullEn    ()
    );
endmodule

// File: rtl/pdp_regs.vh
// Register offsets, reset values and mode codes for the port direction and pull-up block
`ifndef PDP_REGS_VH
`define PDP_REGS_VH
`define PDP_IDX_P3PULL   8'hAE
`define PDP_IDX_P1DIR    8'hB0
`define PDP_IDX_P1LATCH  8'hB2
`define PDP_IDX_P2DIR    8'hB1
`define PDP_IDX_P2LATCH  8'hB3
`define PDP_RST_PULL     8'h00
`define PDP_RST_LATCH    8'h00
`define PDP_RST_DIR_M1   8'hFF
`define PDP_RST_DIR_M23  8'h00
`define PDP_MODE_1       2'h1
`define PDP_ADDR_W       10
`endif

// File: rtl/pdp_pin_drive.v
// Per-pin output driver and pull-up control for one eight-bit port
`timescale 1ns/1ps
module pdp_pin_drive (
    dirBits,
    latchBits,
    pullBits,
    pinOut,
    pinOe,
    pullEn
);
    input  wire [7:0] dirBits;
    input  wire [7:0] latchBits;
    input  wire [7:0] pullBits;
    output wire [7:0] pinOut;
    output wire [7:0] pinOe;
    output wire [7:0] pullEn;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : gPin
            // Output drives latch; input leaves the pin undriven
            assign pinOe[i]  = dirBits[i];
            assign pinOut[i] = dirBits[i] & latchBits[i];
            // Pull-up only on a pin set as input
            assign pullEn[i] = pullBits[i] & ~dirBits[i];
        end
    endgenerate
endmodule

// File: bench/pdp_pin_model.sv
// Pin model for ports 1 and 2
`timescale 1ns/1ps
module pdp_pin_model(input wire [7:0] out1,input wire [7:0] oe1,input wire [7:0] out2,input wire [7:0] oe2,
    output wire [7:0] pad1,output wire [7:0] pad2);
    assign pad1 = (oe1 & out1) | (~oe1 & 8'hA5);
    assign pad2 = (oe2 & out2) | (~oe2 & 8'h5A);
endmodule

// File: bench/pdp_monitor.sv
// Checker for the port register block
`timescale 1ns/1ps
module pdp_monitor(input wire ref_clk,input wire srst,input wire [1:0] opMode,input wire psel,input wire penable,
    input wire pwrite,input wire [11:0] paddr,input wire [31:0] pwdata,input wire [31:0] prdata,
    input wire [7:0] port1Out,input wire [7:0] port1Oe,input wire [7:0] port2Out,input wire [7:0] port3PullEn);
    wire wr = psel && penable && pwrite;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_undriven_quiet: assert property ((port1Out & ~port1Oe) == 8'h00) else $error("undriven pin has data");
    a_mode1_out: assert property (opMode == 2'h1 [*3] |-> port1Oe == 8'hFF) else $error("mode 1 not output");
    a_dir_hidden: assert property (psel && penable && !pwrite && paddr == 12'h2C0 |-> prdata == 32'h0)
        else $error("direction readable");
    a_pull_write: assert property (wr && paddr == 12'h2B8 |=> port3PullEn == $past(pwdata[7:0]))
        else $error("pull-up write lost");
    a_dir_write: assert property (wr && paddr == 12'h2C0 && opMode == 2'h2 |=> port1Oe == $past(pwdata[7:0]))
        else $error("direction write lost");
    a_rst_clear: assert property ($fell(srst) |-> port3PullEn == 8'h00 && port1Out == 8'h00 && port2Out == 8'h00)
        else $error("reset values wrong");
endmodule
bind pdp_port_regs pdp_monitor pdp_monitor_inst(.ref_clk,.srst,.opMode,.psel,.penable,.pwrite,.paddr,.pwdata,
    .prdata,.port1Out,.port1Oe,.port2Out,.port3PullEn);

// File: bench/tb.sv
// Testbench for the port register block
`timescale 1ns/1ps
module tb;
    logic ref_clk=0,srst=1,psel=0,penable=0,pwrite=0;
    logic [1:0] opMode=2'h2;
    logic [11:0] paddr=0;
    logic [31:0] pwdata=0;
    wire pready,pslverr;
    wire [31:0] prdata;
    wire [7:0] port1Out,port1Oe,port2Out,port2Oe,port3PullEn,pad1,pad2;
    int errors=0,cmp_count=0,cyc=0,i;
    logic [31:0] rd=0;
    logic er=0;
    logic [27:0] rows[5]='{{12'h2B8,8'hA5,8'hA5},{12'h2C8,8'h3C,8'h3C},{12'h2CC,8'hC3,8'hC3},{12'h2C0,8'hF0,8'h00},
        {12'h004,8'hFF,8'h00}};
    pdp_port_regs pdp_port_regs_inst(.ref_clk,.srst,.opMode,.psel,.penable,.pwrite,.paddr,.pwdata,.pready,.pslverr,
        .prdata,.port1Out,.port1Oe,.port2Out,.port2Oe,.port3PullEn);
    pdp_pin_model pdp_pin_model_inst(.out1(port1Out),.oe1(port1Oe),.out2(port2Out),.oe2(port2Oe),.pad1,.pad2);
    initial forever #2 ref_clk = ~ref_clk;
    task results; begin
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish; end endtask
    task chk(input string n, input [31:0] s, input [31:0] e); begin
        cmp_count++;
        if (s !== e) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end endtask
    task apb(input [11:0] a, input [7:0] d, input w); begin
        @(posedge ref_clk); psel <= 1; paddr <= a; pwdata <= {24'h0, d}; pwrite <= w;
        @(posedge ref_clk); penable <= 1;
        @(posedge ref_clk); while (!pready) @(posedge ref_clk);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0; @(posedge ref_clk); end endtask
    always @(posedge ref_clk) begin cyc++; if (cyc == 2000) begin errors++; results; end end
    initial begin
        repeat (8) @(posedge ref_clk); srst <= 0;
        apb(12'h2B8, 8'h00, 0); chk("pull reset", rd, 32'h0);
        for (i = 0; i < 5; i++) begin
            apb(rows[i][27:16], rows[i][15:8], 1); apb(rows[i][27:16], 8'h00, 0);
            chk("read back", rd, {24'h0, rows[i][7:0]}); end
        chk("unmapped err", {31'h0, er}, 32'h1);
        apb(12'h2C8, 8'h00, 0); chk("mapped no err", {31'h0, er}, 32'h0);
        chk("pull pins", port3PullEn, 32'hA5);
        chk("pad1", pad1, 32'h35);
        opMode <= 2'h1; repeat (3) @(posedge ref_clk); chk("mode1 dir", {port1Oe, port2Oe}, 32'hFFFF);
        apb(12'h2C4, 8'h00, 1); chk("mode1 write", port2Oe, 32'hFF);
        chk("port2 drive", port2Out, 32'hC3);
        srst <= 1; repeat (2) @(posedge ref_clk); srst <= 0; @(posedge ref_clk);
        chk("mode1 reset dir", port1Oe, 32'hFF);
        chk("mode1 reset out", port2Out, 32'h0);
        opMode <= 2'h2; srst <= 1; repeat (2) @(posedge ref_clk); srst <= 0; @(posedge ref_clk);
        chk("mode2 reset dir", port1Oe, 32'h0);
        chk("mode2 reset pull", port3PullEn, 32'h0);
        results;
    end
endmodule
